/* File: rsrc_pkg.sv */
// Functional notes
// RQ1 - system reset clears registers, core, 66 cycles
// RQ2 - recovery resets core, keeps most registers
// RQ3 - recovery latency at least 66 cycles
// RQ4 - watchdog reset time-out in stop recovers
// RQ5 - watchdog exception time-out recovers then raises exception
// RQ6 - enabled pin level change in stop recovers
// RQ7 - count latency, release core at end
`default_nettype none
package rsrc_pkg;
  localparam int unsigned RSRC_OSC_MHZ = 100;
  localparam int unsigned RSRC_LATENCY_CYC = 66;
  localparam int unsigned RSRC_CNT_W = 8;
  localparam logic [RSRC_CNT_W-1:0] RSRC_CNT_ZERO = 8'h00;
  localparam logic [RSRC_CNT_W-1:0] RSRC_CNT_ONE = 8'h01;
  typedef enum logic [1:0] {RSRC_RUN, RSRC_SYS_HOLD, RSRC_SMR_HOLD} rsrc_state_t;
endpackage
`default_nettype wire

/* File: rsrc_latency_counter.sv */
`default_nettype none
module rsrc_latency_counter
  import rsrc_pkg::*;
#(
  parameter int unsigned CYCLES = RSRC_LATENCY_CYC
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic start,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [RSRC_CNT_W-1:0] cnt_ff;
  } rsrc_cnt_state_t;
  localparam logic [RSRC_CNT_W-1:0] LOAD = CYCLES[RSRC_CNT_W-1:0];
  rsrc_cnt_state_t st_ff;
  rsrc_cnt_state_t nxt_st;
  ////////////////////////////////////////////////////////////////
  // load on start, count down to zero
  always_comb
  begin
    nxt_st = st_ff;
    if (start)
    begin
      nxt_st.cnt_ff = LOAD;
    end
    else if (st_ff.cnt_ff != RSRC_CNT_ZERO)
    begin
      nxt_st.cnt_ff = st_ff.cnt_ff - RSRC_CNT_ONE;
    end
  end
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st_ff.cnt_ff <= LOAD; // hold count runs from reset
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  assign busy = (st_ff.cnt_ff != RSRC_CNT_ZERO);
  assign done = (st_ff.cnt_ff == RSRC_CNT_ONE) && !start;
endmodule // rsrc_latency_counter
`default_nettype wire

/* File: rsrc_reset_ctrl.sv */
`default_nettype none
module rsrc_reset_ctrl
  import rsrc_pkg::*;
#(
  parameter int unsigned GPIO_W = 8,
  parameter int unsigned LATENCY = RSRC_LATENCY_CYC
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SYS_RESET_REQ,
  input wire logic STOP_MODE,
  input wire logic WDT_TIMEOUT,
  input wire logic WDT_RESET_MODE,
  input wire logic [GPIO_W-1:0] GPIO_IN,
  input wire logic [GPIO_W-1:0] GPIO_SMR_EN,
  output logic CORE_RST,
  output logic PERIPH_RST,
  output logic CAUSE_OSC_RST,
  output logic SMR_ACTIVE,
  output logic SMR_BY_WDT,
  output logic SMR_BY_GPIO,
  output logic WDT_SYS_EXC
);
  typedef struct packed {
    rsrc_state_t state_ff;
    logic [GPIO_W-1:0] gpio_ff;
    logic exc_pend_ff;
    logic exc_ff;
    logic by_wdt_ff;
    logic by_gpio_ff;
  } rsrc_ctrl_state_t;
  rsrc_ctrl_state_t st_ff;
  rsrc_ctrl_state_t nxt_st;
  logic cnt_start;
  logic cnt_busy;
  logic cnt_done;
  logic gpio_change;
  logic wdt_wake;
  ////////////////////////////////////////////////////////////////
  // latency counter
  rsrc_latency_counter #(.CYCLES(LATENCY)) u_cnt (
    .CLK(CLK),
    .SRST(SRST),
    .start(cnt_start),
    .busy(cnt_busy),
    .done(cnt_done)
  );
  ////////////////////////////////////////////////////////////////
  // wake sources while stopped
  assign gpio_change = |((GPIO_IN ^ st_ff.gpio_ff) & GPIO_SMR_EN); // see RQ6
  assign wdt_wake = WDT_TIMEOUT; // see RQ4
  // sequencing
  always_comb
  begin
    nxt_st = st_ff;
    cnt_start = 1'b0;
    nxt_st.gpio_ff = GPIO_IN;
    nxt_st.exc_ff = 1'b0;
    case (st_ff.state_ff)
      RSRC_RUN:
      begin
        if (SYS_RESET_REQ)
        begin
          nxt_st.state_ff = RSRC_SYS_HOLD; // see RQ1
          nxt_st.exc_pend_ff = 1'b0;
          cnt_start = 1'b1;
        end
        else if (STOP_MODE && (wdt_wake || gpio_change))
        begin
          nxt_st.state_ff = RSRC_SMR_HOLD; // see RQ2
          nxt_st.by_wdt_ff = wdt_wake;
          nxt_st.by_gpio_ff = gpio_change;
          nxt_st.exc_pend_ff = wdt_wake && !WDT_RESET_MODE; // see RQ5
          cnt_start = 1'b1;
        end
      end
      RSRC_SYS_HOLD, RSRC_SMR_HOLD:
      begin
        if (SYS_RESET_REQ && st_ff.state_ff == RSRC_SMR_HOLD)
        begin
          nxt_st.state_ff = RSRC_SYS_HOLD; // system reset overrides
          nxt_st.exc_pend_ff = 1'b0;
          cnt_start = 1'b1;
        end
        else if (cnt_done)
        begin
          nxt_st.state_ff = RSRC_RUN; // see RQ7
          nxt_st.exc_ff = st_ff.exc_pend_ff; // see RQ5
          nxt_st.exc_pend_ff = 1'b0;
        end
      end
      default:
      begin
        nxt_st.state_ff = RSRC_SYS_HOLD;
        cnt_start = 1'b1;
      end
    endcase
  end
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st_ff.state_ff <= RSRC_SYS_HOLD; // see RQ1
      st_ff.gpio_ff <= '0;
      st_ff.exc_pend_ff <= 1'b0;
      st_ff.exc_ff <= 1'b0;
      st_ff.by_wdt_ff <= 1'b0;
      st_ff.by_gpio_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  ////////////////////////////////////////////////////////////////
  // outputs
  assign CORE_RST = (st_ff.state_ff != RSRC_RUN); // see RQ3
  assign PERIPH_RST = (st_ff.state_ff == RSRC_SYS_HOLD); // see RQ2
  assign CAUSE_OSC_RST = (st_ff.state_ff != RSRC_RUN);
  assign SMR_ACTIVE = (st_ff.state_ff == RSRC_SMR_HOLD);
  assign SMR_BY_WDT = st_ff.by_wdt_ff;
  assign SMR_BY_GPIO = st_ff.by_gpio_ff;
  assign WDT_SYS_EXC = st_ff.exc_ff;
endmodule // rsrc_reset_ctrl
`default_nettype wire

/* File: rsrc_reset_ctrl_properties.sv */
`default_nettype none
module rsrc_chk
  import rsrc_pkg::*;
#(parameter int unsigned GPIO_W = 8, parameter int unsigned LATENCY = RSRC_LATENCY_CYC)
(input wire logic CLK, SRST, SYS_RESET_REQ, STOP_MODE, WDT_TIMEOUT, WDT_RESET_MODE, CORE_RST, PERIPH_RST,
 input wire logic SMR_ACTIVE, WDT_SYS_EXC, SMR_BY_WDT,
 input wire logic [GPIO_W-1:0] GPIO_IN, GPIO_SMR_EN);
  int unsigned n_ff;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // counts cycles of core reset since it rose
  always_ff @(posedge CLK) n_ff <= (SRST || !CORE_RST) ? 0 : n_ff + 1;
  a_hold_len: assert property ($fell(CORE_RST) |-> n_ff == LATENCY) else $error("bad hold");
  a_smr_len: assert property ($fell(SMR_ACTIVE) && !CORE_RST |-> n_ff == LATENCY) else $error("bad smr");
  a_sys_take: assert property (!CORE_RST && SYS_RESET_REQ |=> PERIPH_RST) else $error("no sys");
  a_smr_keep: assert property (SMR_ACTIVE |-> CORE_RST && !PERIPH_RST) else $error("smr regs");
  a_wdt_wake: assert property (!CORE_RST && !SYS_RESET_REQ && STOP_MODE && WDT_TIMEOUT |=> SMR_ACTIVE)
    else $error("no wdt wake");
  a_pin_wake: assert property (!CORE_RST && !SYS_RESET_REQ && STOP_MODE
    && |((GPIO_IN ^ $past(GPIO_IN)) & GPIO_SMR_EN) |=> SMR_ACTIVE) else $error("no pin wake");
  a_exc_pulse: assert property ($fell(SMR_ACTIVE) && !CORE_RST && SMR_BY_WDT && !$past(WDT_RESET_MODE)
    |-> WDT_SYS_EXC ##1 !WDT_SYS_EXC) else $error("bad exc");
endmodule // rsrc_chk
bind rsrc_reset_ctrl rsrc_chk #(.GPIO_W(GPIO_W), .LATENCY(LATENCY)) i_chk(.*);
`default_nettype wire

/* File: rsrc_far.sv */
`default_nettype none
module rsrc_far
(input wire logic CLK, input wire logic [1:0] cmd, input wire logic [7:0] pin,
 output logic wdt_to = 0, output logic [7:0] gpio = 8'h00);
  // watchdog pulse or pin toggle on the falling edge
  always @(negedge CLK)
  begin
    wdt_to <= cmd == 2'h1;
    gpio <= cmd == 2'h2 ? gpio ^ pin : gpio;
  end
endmodule // rsrc_far
`default_nettype wire

/* File: rsrc_reset_ctrl_bench.sv */
`default_nettype none
module rsrc_reset_ctrl_bench import rsrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, SRST = 1, SYS_RESET_REQ = 0, STOP_MODE = 0, WDT_RESET_MODE = 0, WDT_TIMEOUT;
  logic CORE_RST, PERIPH_RST, WDT_SYS_EXC, CAUSE_OSC_RST, SMR_BY_WDT, SMR_BY_GPIO;
  logic [1:0] cmd = 2'h0;
  logic [7:0] pin = 8'h00, GPIO_IN, GPIO_SMR_EN = 8'h00;
  int n_fail = 0, checks_done = 0, k, kind;
  // clock
  always #5 CLK = ~CLK;
  rsrc_far i_far(.CLK(CLK), .cmd(cmd), .pin(pin), .wdt_to(WDT_TIMEOUT), .gpio(GPIO_IN));
  rsrc_reset_ctrl i_dut(.*, .SMR_ACTIVE());
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #100000;
    n_fail++;
    report_and_stop;
  end
  // reset, then back to back requests and wakes
  initial
  begin
    void'($urandom(81172));
    repeat (10) @(negedge CLK);
    SRST = 0;
    chk(PERIPH_RST, 1);
    for (int t = 0; t < 16; t++)
    begin
      for (k = 0; CORE_RST !== 1'b0 && k < 300; k++) @(negedge CLK);
      if (k == 300) n_fail++;
      kind = t < 4 ? t : $urandom_range(3);
      pin = 8'h01 << $urandom_range(7);
      GPIO_SMR_EN = pin | 8'($urandom);
      STOP_MODE = kind != 0;
      WDT_RESET_MODE = kind == 1;
      SYS_RESET_REQ = kind == 0;
      cmd <= kind == 3 ? 2'h2 : 2'(kind != 0);
      @(negedge CLK);
      SYS_RESET_REQ = 0;
      cmd <= 2'h0;
      for (k = 0; CORE_RST !== 1'b1 && k < 4; k++) @(negedge CLK);
      chk(8'(CORE_RST), 8'h01);
      chk(8'(CAUSE_OSC_RST), 8'h01);
      if (kind != 0)
      begin
        chk(8'({SMR_BY_WDT, SMR_BY_GPIO}), kind == 3 ? 8'h01 : 8'h02);
      end
      chk(PERIPH_RST, 8'(kind == 0));
      for (k = 0; CORE_RST === 1'b1 && k < 300; k++) @(negedge CLK);
      chk(8'(k), 8'(RSRC_LATENCY_CYC));
      chk(WDT_SYS_EXC, 8'(kind == 2));
      $display("test %0d kind %0d done", t, kind);
    end
    report_and_stop;
  end
endmodule // rsrc_reset_ctrl_bench
`default_nettype wire
